// File: include/frs_defs.vh
// Constants for the frequency reference selector: offsets, codes, reset values, timing
`ifndef FRS_DEFS_VH
`define FRS_DEFS_VH
// Register byte offsets
`define FRS_OFF_MAINSRC 8'h00
`define FRS_OFF_AUXSRC 8'h04
`define FRS_OFF_MEMMODE 8'h08
`define FRS_OFF_AUXBASE 8'h0C
`define FRS_OFF_AUXRANGE 8'h10
`define FRS_OFF_OVERLAY 8'h14
`define FRS_OFF_PRESET 8'h18
`define FRS_OFF_MAXFREQ 8'h1C
`define FRS_OFF_UPSRC 8'h20
`define FRS_OFF_UPVAL 8'h24
`define FRS_OFF_LOWVAL 8'h28
`define FRS_OFF_COMMREF 8'h2C
`define FRS_OFF_PCALF0 8'h30
`define FRS_OFF_PCALP0 8'h34
`define FRS_OFF_PCALF1 8'h38
`define FRS_OFF_PCALP1 8'h3C
`define FRS_OFF_FINAL 8'h40
`define FRS_OFF_MAINHZ 8'h44
`define FRS_OFF_AUXHZ 8'h48
`define FRS_OFF_PULSEHZ 8'h4C
`define FRS_OFF_ADJUST 8'h50
`define FRS_OFF_STAGE 8'h54
// Table pages: address bits 7:5, entry in bits 4:2
`define FRS_PAGE_STEP 3'h4
`define FRS_PAGE_HOLD 3'h5
// Source codes
`define FRS_SRC_DIGITAL 4'h0
`define FRS_SRC_ANALOG1 4'h1
`define FRS_SRC_ANALOG2 4'h2
`define FRS_SRC_PULSE 4'h4
`define FRS_SRC_MULTI 4'h5
`define FRS_SRC_SEQ 4'h6
`define FRS_SRC_PID 4'h7
`define FRS_SRC_COMM 4'h8
// Overlay units digit and tens digit
`define FRS_OV_MAIN 4'h0
`define FRS_OV_COMB 4'h1
`define FRS_OV_MAINAUX 4'h2
`define FRS_OV_MAINCOMB 4'h3
`define FRS_OV_AUXCOMB 4'h4
`define FRS_OP_SUM 2'h0
`define FRS_OP_DIFF 2'h1
`define FRS_OP_MAX 2'h2
`define FRS_OP_MIN 2'h3
// Adjustment memory modes
`define FRS_MEM_NONE 2'h0
`define FRS_MEM_POWER 2'h1
`define FRS_MEM_STOP 2'h2
`define FRS_MEM_BOTH 2'h3
// Upper-limit source codes
`define FRS_UP_VALUE 2'h0
`define FRS_UP_ANALOG1 2'h1
`define FRS_UP_ANALOG2 2'h2
`define FRS_UP_PULSE 2'h3
// Values in 0.01 Hz and 0.01 percent; aux range values in percent, pulse rate top in Hz
`define FRS_HZ_DEFAULT 16'h1388
`define FRS_MAX_LOW 16'h1388
`define FRS_MAX_HIGH 16'hF618
`define FRS_PCT_FULL 32'h0000_2710
`define FRS_RANGE_DEFAULT 8'h64
`define FRS_RANGE_TOP 8'h96
`define FRS_RANGE_UNIT 32'h0000_0064
`define FRS_PULSE_TOP 32'h0000_C350
`define FRS_PULSE_TOP16 16'hC350
`define FRS_PCT_FULL16 16'h2710
`define FRS_SRC_TOP 4'h8
// Timing: clock period and tick time in ns, gate in ticks
`define FRS_CLK_NS 8
`define FRS_TICK_NS 1000000
`define FRS_TICK_CYC (`FRS_TICK_NS / `FRS_CLK_NS)
`define FRS_GATE_TICKS 4'hA
`define FRS_HZ_PER_COUNT 32'h0000_0064
`endif

// File: logic/frs_selector.v
// Frequency reference selector: source decode, main/aux combine, limits, Wishbone registers
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "frs_defs.vh"

module frs_selector #(
  parameter TICK_CYCLES = `FRS_TICK_CYC
)(
  input wire sys_clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire pulseInputTerminal,
  input wire [15:0] analogInputOne,
  input wire [15:0] analogInputTwo,
  input wire [15:0] pidOutput,
  input wire [2:0] stepSelect,
  input wire switchSelect,
  input wire runActive,
  input wire upPulse,
  input wire downPulse,
  input wire restoreStrobe,
  input wire [16:0] adjustRestore,
  output reg [15:0] freqRef,
  output reg [2:0] seqStage,
  output reg [16:0] adjustSave
);

  // Configuration registers
  reg [3:0] mainSrc_reg; // Main source code
  reg [3:0] auxSrc_reg; // Auxiliary source code
  reg [1:0] memMode_reg; // Adjustment memory mode
  reg auxBase_reg; // Aux range base
  reg [7:0] auxRange_reg; // Aux range in percent
  reg [3:0] ovUnits_reg; // Overlay units digit
  reg [1:0] ovTens_reg; // Overlay tens digit
  reg [15:0] preset_reg; // Preset frequency, 0.01 Hz
  reg [15:0] maxFreq_reg; // Maximum frequency, 0.01 Hz
  reg [1:0] upSrc_reg; // Upper-limit source
  reg [15:0] upVal_reg; // Upper-limit value
  reg [15:0] lowVal_reg; // Lower-limit value
  reg [15:0] commRef_reg; // Host reference, 0.01 percent
  reg [15:0] calF0_reg; // Pulse point 0, Hz
  reg [15:0] calP0_reg; // Pulse point 0, 0.01 percent
  reg [15:0] calF1_reg; // Pulse point 1, Hz
  reg [15:0] calP1_reg; // Pulse point 1, 0.01 percent
  reg [15:0] stepPct [0:7]; // Step references, 0.01 percent
  reg [15:0] holdMs [0:7]; // Sequencer hold times in ticks

  // Working state
  reg signed [16:0] adj_reg; // Up/down adjustment
  reg runPrev_reg; // Run level one cycle ago
  reg pulsePrev_reg; // Pulse level one cycle ago
  reg [31:0] tickCnt_reg; // Tick divider
  reg tick_reg; // One-cycle tick enable
  reg [3:0] gateCnt_reg; // Ticks into the gate window
  reg [9:0] edgeCnt_reg; // Edges in the gate window
  reg [15:0] pulseHz_reg; // Measured pulse rate, Hz
  reg [15:0] holdCnt_reg; // Ticks held in current stage
  reg [15:0] mainHz_reg; // Main source, registered
  reg [15:0] auxHz_reg; // Aux source, registered

  // Bus decode
  wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o; // New request
  wire wbWr = wbReq & wb_we_i; // Write strobe
  wire full16 = wb_sel_i[1] & wb_sel_i[0]; // Both low lanes
  wire [15:0] wd = wb_dat_i[15:0]; // Write data
  wire [2:0] page = wb_adr_i[7:5]; // Table page
  wire [2:0] entry = wb_adr_i[4:2]; // Table entry

  // Scale a 0.01 percent value onto a base in 0.01 Hz
  function [15:0] pct2hz;
    input [15:0] pct;
    input [15:0] base;
    reg [31:0] p;
    begin
      p = ({16'h0000, pct} * {16'h0000, base}) / `FRS_PCT_FULL;
      pct2hz = (p > 32'h0000_FFFF) ? 16'hFFFF : p[15:0];
    end
  endfunction

  // Smaller of two frequencies
  function [15:0] min16;
    input [15:0] a;
    input [15:0] b;
    begin
      min16 = (a < b) ? a : b;
    end
  endfunction

  // Digital setting: preset plus adjustment, held in 0..maximum
  wire signed [17:0] digSum = $signed({2'b00, preset_reg}) + {adj_reg[16], adj_reg};
  wire [15:0] digHz = digSum[17] ? 16'h0000 :
    ((digSum[16:0] > {1'b0, maxFreq_reg}) ? maxFreq_reg : digSum[15:0]);

  // Pulse calibration: clamp into the two points, then interpolate
  reg [31:0] pulsePct; // Result in 0.01 percent
  reg [31:0] pf; // Clamped input rate
  reg signed [33:0] slope; // Interpolation term
  always @*
  begin
    pulsePct = {16'h0000, calP0_reg};
    pf = {16'h0000, pulseHz_reg};
    slope = 34'sh0;
    if (calF1_reg > calF0_reg) // Degenerate line keeps point 0
    begin
      if (pf < {16'h0000, calF0_reg})
        pf = {16'h0000, calF0_reg};
      if (pf > {16'h0000, calF1_reg})
        pf = {16'h0000, calF1_reg};
      slope = ($signed({2'b00, pf - {16'h0000, calF0_reg}}) *
        ($signed({18'h0, calP1_reg}) - $signed({18'h0, calP0_reg}))) /
        $signed({18'h0, calF1_reg - calF0_reg});
      pulsePct = slope[31:0] + {16'h0000, calP0_reg};
    end
  end
  wire [15:0] pulsePct16 = pulsePct[15:0];

  // Map a source code to a frequency; shared by main and aux selectors
  function [15:0] srcHz;
    input [3:0] code;
    begin
      case (code)
        `FRS_SRC_DIGITAL: srcHz = digHz;
        `FRS_SRC_ANALOG1: srcHz = pct2hz(analogInputOne, maxFreq_reg);
        `FRS_SRC_ANALOG2: srcHz = pct2hz(analogInputTwo, maxFreq_reg);
        `FRS_SRC_PULSE: srcHz = pct2hz(pulsePct16, maxFreq_reg);
        `FRS_SRC_MULTI: srcHz = pct2hz(stepPct[stepSelect], maxFreq_reg);
        `FRS_SRC_SEQ: srcHz = pct2hz(stepPct[seqStage], maxFreq_reg);
        `FRS_SRC_PID: srcHz = pct2hz(pidOutput, maxFreq_reg);
        `FRS_SRC_COMM: srcHz = pct2hz(commRef_reg, maxFreq_reg);
        default: srcHz = 16'h0000; // Unused code 3 gives zero
      endcase
    end
  endfunction

  // Superposition applies only to overlay choices that use the combined value
  wire superpose = (ovUnits_reg == `FRS_OV_COMB) | (ovUnits_reg == `FRS_OV_MAINCOMB) |
    (ovUnits_reg == `FRS_OV_AUXCOMB);

  // Aux span: base is maximum or main command, then range percent
  reg [31:0] auxSpan; // Scaled aux, 0.01 Hz
  reg [15:0] auxEff; // Aux as used by combine
  always @*
  begin
    auxSpan = {16'h0000, auxHz_reg};
    if (auxBase_reg)
      auxSpan = (auxSpan * {16'h0000, mainHz_reg}) / {16'h0000, maxFreq_reg};
    auxSpan = (auxSpan * {24'h0, auxRange_reg}) / `FRS_RANGE_UNIT;
    auxEff = (auxSpan > 32'h0000_FFFF) ? 16'hFFFF : auxSpan[15:0];
    if (!superpose)
      auxEff = auxHz_reg;
  end

  // Combine main and aux, then add the preset on top
  reg [17:0] comb; // Combined value, wide to avoid wrap
  always @*
  begin
    case (ovTens_reg)
      `FRS_OP_SUM: comb = {2'b00, mainHz_reg} + {2'b00, auxEff};
      `FRS_OP_DIFF: comb = (mainHz_reg > auxEff) ? {2'b00, mainHz_reg - auxEff} : 18'h0;
      `FRS_OP_MAX: comb = {2'b00, (mainHz_reg > auxEff) ? mainHz_reg : auxEff};
      `FRS_OP_MIN: comb = {2'b00, min16(mainHz_reg, auxEff)};
      default: comb = 18'h0;
    endcase
    comb = comb + {2'b00, preset_reg};
  end
  wire [15:0] comb16 = (comb > 18'h0FFFF) ? 16'hFFFF : comb[15:0];

  // Final selection by units digit; the switch input chooses the second member
  reg [15:0] chosen; // Reference before limits
  always @*
  begin
    case (ovUnits_reg)
      `FRS_OV_MAIN: chosen = mainHz_reg;
      `FRS_OV_COMB: chosen = comb16;
      `FRS_OV_MAINAUX: chosen = switchSelect ? auxHz_reg : mainHz_reg;
      `FRS_OV_MAINCOMB: chosen = switchSelect ? comb16 : mainHz_reg;
      `FRS_OV_AUXCOMB: chosen = switchSelect ? comb16 : auxHz_reg;
      default: chosen = mainHz_reg;
    endcase
  end

  // Upper limit: analog and pulse percent are taken against the value setting
  reg [15:0] upperHz; // Active upper limit
  always @*
  begin
    case (upSrc_reg)
      `FRS_UP_VALUE: upperHz = upVal_reg;
      `FRS_UP_ANALOG1: upperHz = pct2hz(analogInputOne, upVal_reg);
      `FRS_UP_ANALOG2: upperHz = pct2hz(analogInputTwo, upVal_reg);
      `FRS_UP_PULSE: upperHz = pct2hz(pulsePct16, upVal_reg);
      default: upperHz = upVal_reg;
    endcase
  end
  wire [15:0] limitHz = min16(upperHz, maxFreq_reg);
  wire [15:0] finalHz = min16(chosen, limitHz);

  // Write acceptance checks; out-of-range writes are dropped
  wire maxOk = (wd >= `FRS_MAX_LOW) & (wd <= `FRS_MAX_HIGH);
  wire presetOk = (wd <= maxFreq_reg);
  wire upOk = (wd >= lowVal_reg) & (wd <= maxFreq_reg);
  wire lowOk = (wd <= upVal_reg);
  wire rangeOk = (wd <= {8'h00, `FRS_RANGE_TOP});
  wire srcOk = (wd[3:0] <= `FRS_SRC_TOP) & (wd[15:4] == 12'h000);

  // Register writes
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mainSrc_reg <= `FRS_SRC_DIGITAL;
      auxSrc_reg <= `FRS_SRC_DIGITAL;
      memMode_reg <= `FRS_MEM_NONE;
      auxBase_reg <= 1'b0;
      auxRange_reg <= `FRS_RANGE_DEFAULT;
      ovUnits_reg <= `FRS_OV_MAIN;
      ovTens_reg <= `FRS_OP_SUM;
      preset_reg <= `FRS_HZ_DEFAULT;
      maxFreq_reg <= `FRS_HZ_DEFAULT;
      upSrc_reg <= `FRS_UP_VALUE;
      upVal_reg <= `FRS_HZ_DEFAULT;
      lowVal_reg <= 16'h0000;
      commRef_reg <= 16'h0000;
      calF0_reg <= 16'h0000;
      calP0_reg <= 16'h0000;
      calF1_reg <= `FRS_PULSE_TOP16;
      calP1_reg <= `FRS_PCT_FULL16;
    end
    else if (wbWr & full16)
    begin
      case (wb_adr_i)
        `FRS_OFF_MAINSRC: if (srcOk) mainSrc_reg <= wd[3:0];
        `FRS_OFF_AUXSRC: if (srcOk) auxSrc_reg <= wd[3:0];
        `FRS_OFF_MEMMODE: memMode_reg <= wd[1:0];
        `FRS_OFF_AUXBASE: auxBase_reg <= wd[0];
        `FRS_OFF_AUXRANGE: if (rangeOk) auxRange_reg <= wd[7:0];
        `FRS_OFF_OVERLAY:
          if (wd[3:0] <= `FRS_OV_AUXCOMB)
          begin
            ovUnits_reg <= wd[3:0];
            ovTens_reg <= wd[5:4];
          end
        `FRS_OFF_PRESET: if (presetOk) preset_reg <= wd;
        `FRS_OFF_MAXFREQ: if (maxOk) maxFreq_reg <= wd;
        `FRS_OFF_UPSRC: upSrc_reg <= wd[1:0];
        `FRS_OFF_UPVAL: if (upOk) upVal_reg <= wd;
        `FRS_OFF_LOWVAL: if (lowOk) lowVal_reg <= wd;
        `FRS_OFF_COMMREF: commRef_reg <= wd;
        `FRS_OFF_PCALF0: calF0_reg <= wd;
        `FRS_OFF_PCALP0: calP0_reg <= wd;
        `FRS_OFF_PCALF1: calF1_reg <= wd;
        `FRS_OFF_PCALP1: calP1_reg <= wd;
        default: ; // Tables and read-only words handled elsewhere
      endcase
    end
  end

  // Step and hold tables; no reset, software loads them before use
  always @(posedge sys_clk)
  begin
    if (wbWr & full16 & (page == `FRS_PAGE_STEP))
      stepPct[entry] <= wd;
    if (wbWr & full16 & (page == `FRS_PAGE_HOLD))
      holdMs[entry] <= wd;
  end

  // Bus answer: ack one cycle after the request, read data from a flop
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wbReq;
      if (wbReq & ~wb_we_i)
      begin
        case (wb_adr_i)
          `FRS_OFF_MAINSRC: wb_dat_o <= {28'h0, mainSrc_reg};
          `FRS_OFF_AUXSRC: wb_dat_o <= {28'h0, auxSrc_reg};
          `FRS_OFF_MEMMODE: wb_dat_o <= {30'h0, memMode_reg};
          `FRS_OFF_AUXBASE: wb_dat_o <= {31'h0, auxBase_reg};
          `FRS_OFF_AUXRANGE: wb_dat_o <= {24'h0, auxRange_reg};
          `FRS_OFF_OVERLAY: wb_dat_o <= {26'h0, ovTens_reg, ovUnits_reg};
          `FRS_OFF_PRESET: wb_dat_o <= {16'h0, preset_reg};
          `FRS_OFF_MAXFREQ: wb_dat_o <= {16'h0, maxFreq_reg};
          `FRS_OFF_UPSRC: wb_dat_o <= {30'h0, upSrc_reg};
          `FRS_OFF_UPVAL: wb_dat_o <= {16'h0, upVal_reg};
          `FRS_OFF_LOWVAL: wb_dat_o <= {16'h0, lowVal_reg};
          `FRS_OFF_COMMREF: wb_dat_o <= {16'h0, commRef_reg};
          `FRS_OFF_PCALF0: wb_dat_o <= {16'h0, calF0_reg};
          `FRS_OFF_PCALP0: wb_dat_o <= {16'h0, calP0_reg};
          `FRS_OFF_PCALF1: wb_dat_o <= {16'h0, calF1_reg};
          `FRS_OFF_PCALP1: wb_dat_o <= {16'h0, calP1_reg};
          `FRS_OFF_FINAL: wb_dat_o <= {16'h0, freqRef};
          `FRS_OFF_MAINHZ: wb_dat_o <= {16'h0, mainHz_reg};
          `FRS_OFF_AUXHZ: wb_dat_o <= {16'h0, auxHz_reg};
          `FRS_OFF_PULSEHZ: wb_dat_o <= {16'h0, pulseHz_reg};
          `FRS_OFF_ADJUST: wb_dat_o <= {{15{adj_reg[16]}}, adj_reg};
          `FRS_OFF_STAGE: wb_dat_o <= {29'h0, seqStage};
          default:
            if (page == `FRS_PAGE_STEP)
              wb_dat_o <= {16'h0, stepPct[entry]};
            else if (page == `FRS_PAGE_HOLD)
              wb_dat_o <= {16'h0, holdMs[entry]};
            else
              wb_dat_o <= 32'h0000_0000; // Unmapped reads zero
        endcase
      end
    end
  end

  // Tick divider; tick period sets gate and hold time resolution
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tickCnt_reg <= 32'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= (tickCnt_reg == TICK_CYCLES - 1);
      if (tickCnt_reg == TICK_CYCLES - 1)
        tickCnt_reg <= 32'h0;
      else
        tickCnt_reg <= tickCnt_reg + 32'h1;
    end
  end

  // Pulse rate: count rising edges over a fixed gate, scale to Hz
  // Rates above the span are held at the top, never wrapped
  reg [31:0] rateHz; // Rate after the span clamp
  always @*
  begin
    rateHz = {22'h0, edgeCnt_reg} * `FRS_HZ_PER_COUNT;
    if (rateHz > `FRS_PULSE_TOP)
      rateHz = `FRS_PULSE_TOP;
  end
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pulsePrev_reg <= 1'b0;
      gateCnt_reg <= 4'h0;
      edgeCnt_reg <= 10'h0;
      pulseHz_reg <= 16'h0000;
    end
    else
    begin
      pulsePrev_reg <= pulseInputTerminal;
      if (tick_reg & (gateCnt_reg == `FRS_GATE_TICKS - 4'h1))
      begin
        gateCnt_reg <= 4'h0;
        pulseHz_reg <= rateHz[15:0];
        // An edge in the closing cycle opens the next window, so no edge is lost
        edgeCnt_reg <= {9'h000, pulseInputTerminal & ~pulsePrev_reg};
      end
      else
      begin
        if (tick_reg)
          gateCnt_reg <= gateCnt_reg + 4'h1;
        if (pulseInputTerminal & ~pulsePrev_reg & (edgeCnt_reg != 10'h3FF))
          edgeCnt_reg <= edgeCnt_reg + 10'h1;
      end
    end
  end

  // Sequencer: runs while either selector picks it and the drive runs
  wire seqOn = runActive & ((mainSrc_reg == `FRS_SRC_SEQ) | (auxSrc_reg == `FRS_SRC_SEQ));
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      seqStage <= 3'h0;
      holdCnt_reg <= 16'h0;
    end
    else if (!seqOn)
    begin
      seqStage <= 3'h0; // Restart from the first stage
      holdCnt_reg <= 16'h0;
    end
    else if (tick_reg)
    begin
      if (holdCnt_reg >= holdMs[seqStage])
      begin
        seqStage <= seqStage + 3'h1;
        holdCnt_reg <= 16'h0;
      end
      else
        holdCnt_reg <= holdCnt_reg + 16'h1;
    end
  end

  // Up/down adjustment with its memory modes
  // A restore after power-up outranks a stop in the same cycle
  wire stopEdge = runPrev_reg & ~runActive;
  wire keepPower = (memMode_reg == `FRS_MEM_POWER) | (memMode_reg == `FRS_MEM_BOTH);
  wire keepStop = (memMode_reg == `FRS_MEM_STOP) | (memMode_reg == `FRS_MEM_BOTH);
  wire digUsed = (mainSrc_reg == `FRS_SRC_DIGITAL) | (auxSrc_reg == `FRS_SRC_DIGITAL);
  reg signed [16:0] adj_next; // Next adjustment
  always @*
  begin
    adj_next = adj_reg;
    if (restoreStrobe)
      adj_next = keepPower ? adjustRestore : 17'sh0;
    else if (stopEdge & ~keepStop)
      adj_next = 17'sh0;
    else if (digUsed & upPulse & ~downPulse & (digHz < maxFreq_reg))
      adj_next = adj_reg + 17'sh1;
    else if (digUsed & downPulse & ~upPulse & (digHz != 16'h0000))
      adj_next = adj_reg - 17'sh1;
  end

  // Adjustment state; power-up clears it until a restore arrives
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      adj_reg <= 17'sh0;
      runPrev_reg <= 1'b0;
      adjustSave <= 17'h0;
    end
    else
    begin
      adj_reg <= adj_next;
      runPrev_reg <= runActive;
      adjustSave <= adj_next;
    end
  end

  // Source and output pipeline; one register stage breaks the long arithmetic path
  always @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mainHz_reg <= 16'h0000;
      auxHz_reg <= 16'h0000;
      freqRef <= 16'h0000;
    end
    else
    begin
      mainHz_reg <= srcHz(mainSrc_reg);
      auxHz_reg <= srcHz(auxSrc_reg);
      freqRef <= finalHz;
    end
  end

endmodule // frs_selector

// File: sim/frs_pulse_src.sv
// Pulse train source standing in for the high-speed input terminal
`timescale 1ns/100ps
module frs_pulse_src (
  input wire sys_clk,
  input wire [7:0] halfCycles,
  output reg pulseInputTerminal
);
  reg [7:0] cntReg; // Clocks since last toggle
  initial
  begin
    cntReg = 8'h00;
    pulseInputTerminal = 1'h0;
  end
  // Toggle each halfCycles clocks; zero parks the line low, as an idle terminal
  always @(posedge sys_clk)
  begin
    if (halfCycles == 8'h00)
      pulseInputTerminal <= 1'h0;
    else if (cntReg + 8'h01 >= halfCycles)
    begin
      cntReg <= 8'h00;
      pulseInputTerminal <= !pulseInputTerminal;
    end
    else
      cntReg <= cntReg + 8'h01;
  end
endmodule // frs_pulse_src

// File: sim/frs_selector_chk.sv
// Port checker for the frequency reference selector, bound to the design
`timescale 1ns/100ps
module frs_selector_chk (
  input wire sys_clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire runActive,
  input wire restoreStrobe,
  input wire [15:0] freqRef,
  input wire [2:0] seqStage,
  input wire [16:0] adjustSave
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // A request is taken while strobed and not yet answered
  sequence busTake;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // The answer is a single-cycle pulse
  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_after_take: assert property (busTake |=> ackPulse) else $error("ack not one cycle after request");
  chk_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  chk_dat_on_read: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i) else $error("read data moved");
  chk_ref_max_bound: assert property (freqRef <= 16'hF618) else $error("reference above top maximum");
  chk_stage_idle_zero: assert property (!runActive [*3] |-> seqStage == 3'h0) else $error("stage kept");
  chk_stage_one_step: assert property ($changed(seqStage) |->
    seqStage == $past(seqStage) + 3'h1 || seqStage == 3'h0) else $error("stage skipped");
  // Without a restore the adjustment moves by one count or clears
  chk_adjust_one_count: assert property (
    $changed(adjustSave) && !$past(restoreStrobe) && !$past(restoreStrobe, 2)
    |-> adjustSave == 17'h0 || adjustSave - $past(adjustSave) == 17'h1 || $past(adjustSave) - adjustSave == 17'h1)
    else $error("adjustment jumped");
endmodule // frs_selector_chk

bind frs_selector frs_selector_chk i_frs_selector_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .runActive(runActive),
  .restoreStrobe(restoreStrobe), .freqRef(freqRef), .seqStage(seqStage), .adjustSave(adjustSave));

// File: sim/test_frs_selector.sv
// Self-checking bench for the frequency reference selector
`timescale 1ns/100ps
module test_frs_selector;
  reg sys_clk, sys_rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, switchSelect = 1'h0;
  reg runActive = 1'h0, upPulse = 1'h0, downPulse = 1'h0, restoreStrobe = 1'h0;
  reg [7:0] wb_adr_i = 8'h00, halfCycles = 8'h00, selAdr = 8'h00;
  reg [3:0] wb_sel_i = 4'hF;
  reg [31:0] wb_dat_i = 32'h0, rd;
  reg [15:0] analogInputOne = 16'h1388, analogInputTwo = 16'h09C4, pidOutput = 16'h1D4C;
  reg [2:0] stepSelect = 3'h3;
  reg [16:0] adjustRestore = 17'h0;
  wire pulse, wb_ack_o;
  wire [31:0] wb_dat_o;
  wire [15:0] freqRef;
  wire [2:0] seqStage;
  wire [16:0] adjustSave;
  integer bad_count = 0, cmp_count = 0, i;
  // Short tick keeps the pulse gate at 200 clocks
  frs_selector #(.TICK_CYCLES(20)) i_frs_selector (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pulseInputTerminal(pulse), .analogInputOne(analogInputOne),
    .analogInputTwo(analogInputTwo), .pidOutput(pidOutput), .stepSelect(stepSelect), .switchSelect(switchSelect),
    .runActive(runActive), .upPulse(upPulse), .downPulse(downPulse), .restoreStrobe(restoreStrobe),
    .adjustRestore(adjustRestore), .freqRef(freqRef), .seqStage(seqStage), .adjustSave(adjustSave));
  frs_pulse_src i_frs_pulse_src (.sys_clk(sys_clk), .halfCycles(halfCycles), .pulseInputTerminal(pulse));
  // Clock of 8 ns
  initial
  begin
    sys_clk = 1'h0;
    forever #4 sys_clk = !sys_clk;
  end
  task close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // One classic cycle; held until ack is sampled, then released for a gap
  task wbx(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'h1, 1'h1, w, a, d};
      n = 0;
      @(posedge sys_clk);
      while (wb_ack_o !== 1'h1 && n < 20)
      begin
        @(posedge sys_clk);
        n = n + 1;
      end
      rd = wb_dat_o;
      if (n == 20)
      begin
        bad_count = bad_count + 1;
        close_out;
      end
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e)
      begin
        bad_count = bad_count + 1;
        $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] e);
    begin
      wbx(1'h0, a, 32'h0);
      chk("register", e, rd);
    end
  endtask
  // Reference is valid two edges after a change; three gives margin
  task refchk(input [15:0] e);
    begin
      repeat (3) @(posedge sys_clk);
      chk("freqRef", {16'h0, e}, {16'h0, freqRef});
    end
  endtask
  task srcchk(input [3:0] c, input [15:0] e);
    begin
      wbx(1'h1, selAdr, {28'h0, c});
      refchk(e);
    end
  endtask
  task ovchk(input [7:0] v, input [15:0] e);
    begin
      wbx(1'h1, 8'h14, {24'h0, v});
      refchk(e);
    end
  endtask
  // Pin events: up/down step, restore strobe, run level
  task pin(input [1:0] k, input [16:0] v);
    begin
      @(posedge sys_clk);
      if (k == 2'h3)
        runActive <= v[0];
      else
        {restoreStrobe, upPulse, downPulse, adjustRestore} <= {k == 2'h2, k == 2'h1, k == 2'h0, v};
      @(posedge sys_clk);
      {restoreStrobe, upPulse, downPulse} <= 3'h0;
    end
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'h0;
    rdchk(8'h10, 32'h64);
    rdchk(8'h18, 32'h1388);
    rdchk(8'h24, 32'h1388);
    rdchk(8'h60, 32'h0);
    refchk(16'h1388);
    wbx(1'h1, 8'h10, 32'h97);
    rdchk(8'h10, 32'h64);
    wbx(1'h1, 8'h1C, 32'h1387);
    wbx(1'h1, 8'h18, 32'h1389);
    rdchk(8'h1C, 32'h1388);
    rdchk(8'h18, 32'h1388);
    wbx(1'h1, 8'h1C, 32'h4E20);
    wbx(1'h1, 8'h24, 32'h4E20);
    wbx(1'h1, 8'h2C, 32'h0FA0);
    wbx(1'h1, 8'h8C, 32'h0BB8);
    $display("test defaults done");
    // Main selector, then aux through the switch with the same codes
    for (i = 0; i < 2; i = i + 1)
    begin
      selAdr = i ? 8'h04 : 8'h00;
      switchSelect <= i[0];
      wbx(1'h1, 8'h14, i ? 32'h2 : 32'h0);
      srcchk(4'h1, 16'h2710);
      srcchk(4'h2, 16'h1388);
      srcchk(4'h7, 16'h3A98);
      srcchk(4'h8, 16'h1F40);
      srcchk(4'h5, 16'h1770);
      srcchk(4'h9, 16'h1770);
    end
    wbx(1'h1, 8'h00, 32'h1);
    wbx(1'h1, 8'h04, 32'h2);
    $display("test sources done");
    ovchk(8'h01, 16'h4E20);
    ovchk(8'h11, 16'h2710);
    ovchk(8'h21, 16'h3A98);
    ovchk(8'h31, 16'h2710);
    ovchk(8'h03, 16'h4E20);
    switchSelect <= 1'h0;
    ovchk(8'h03, 16'h2710);
    ovchk(8'h04, 16'h1388);
    wbx(1'h1, 8'h10, 32'h32);
    ovchk(8'h01, 16'h445C);
    wbx(1'h1, 8'h10, 32'h64);
    wbx(1'h1, 8'h0C, 32'h1);
    refchk(16'h445C);
    wbx(1'h1, 8'h0C, 32'h0);
    wbx(1'h1, 8'h24, 32'h1F40);
    refchk(16'h1F40);
    wbx(1'h1, 8'h20, 32'h1);
    refchk(16'h0FA0);
    wbx(1'h1, 8'h20, 32'h0);
    wbx(1'h1, 8'h24, 32'h4E20);
    $display("test overlay done");
    ovchk(8'h00, 16'h2710);
    halfCycles <= 8'h05;
    wbx(1'h1, 8'h00, 32'h4);
    repeat (450) @(posedge sys_clk);
    rdchk(8'h4C, 32'h7D0);
    refchk(16'h0320);
    halfCycles <= 8'h00;
    $display("test pulse done");
    wbx(1'h1, 8'h00, 32'h0);
    pin(2'h3, 17'h1);
    for (i = 0; i < 3; i = i + 1)
      pin(2'h1, 17'h0);
    pin(2'h0, 17'h0);
    refchk(16'h138A);
    pin(2'h3, 17'h0);
    refchk(16'h1388);
    wbx(1'h1, 8'h08, 32'h2);
    pin(2'h3, 17'h1);
    pin(2'h1, 17'h0);
    pin(2'h3, 17'h0);
    refchk(16'h1389);
    pin(2'h2, 17'h7);
    refchk(16'h1388);
    wbx(1'h1, 8'h08, 32'h3);
    pin(2'h2, 17'hA);
    pin(2'h3, 17'h1);
    pin(2'h3, 17'h0);
    refchk(16'h1392);
    wbx(1'h1, 8'h08, 32'h1);
    pin(2'h2, 17'h4);
    refchk(16'h138C);
    chk("adjustSave", 32'h4, {15'h0, adjustSave});
    $display("test memory done");
    for (i = 0; i < 8; i = i + 1)
    begin
      wbx(1'h1, 8'h80 + 4 * i, 32'h3E8 * i);
      wbx(1'h1, 8'hA0 + 4 * i, (i == 1) ? 32'hFFFF : 32'h0);
    end
    wbx(1'h1, 8'h00, 32'h6);
    pin(2'h3, 17'h1);
    repeat (70) @(posedge sys_clk);
    // Stage 0 holds one tick, stage 1 holds far longer than this test
    chk("seqStage", 32'h1, {29'h0, seqStage});
    refchk(16'h07D0);
    pin(2'h3, 17'h0);
    refchk(16'h0);
    $display("test sequencer done");
    close_out;
  end
endmodule // test_frs_selector
